// *** logic/port_pattern_gen_change_detect.sv ***
// pattern generator, power-up states and change detection for an eight-line port
//
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module port_pattern_gen_change_detect #(
  parameter int FIFO_DEPTH = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // dma sample stream
  input wire logic dma_valid,
  input wire logic [7:0] dma_data,
  output logic dma_ready,
  // internal strobe sources
  input wire logic analog_in_sample_strobe,
  input wire logic analog_in_convert_strobe,
  input wire logic analog_out_sample_strobe,
  input wire logic [1:0] counter_internal_out,
  input wire logic freq_gen_out,
  input wire logic analog_compare_event,
  // pins
  input wire logic [7:0] primary_port_in,
  output port_pattern_pkg::drive8_t primary_port_drive,
  input wire logic [15:0] programmable_function_terminal_in,
  output port_pattern_pkg::drive16_t programmable_function_terminal_drive,
  input wire logic [7:0] intercard_trigger_bus_in,
  output port_pattern_pkg::drive8_t intercard_trigger_bus_drive,
  input wire logic star_trigger_in,
  output logic star_trigger_out,
  output logic star_trigger_oe_n,
  // event outputs
  output logic change_event,
  output logic change_irq,
  output logic pattern_in_strobe,
  output logic pattern_out_strobe
);
  import port_pattern_pkg::*;
  localparam int AW = $clog2(FIFO_DEPTH);
  localparam logic [AW:0] DEPTH_CNT = (AW + 1)'(FIFO_DEPTH);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic pwr_drives(input logic [1:0] st);
    return (st == PWR_LOW) || (st == PWR_HIGH);
  endfunction : pwr_drives

  function automatic logic pick_source(input logic [5:0] sel, input logic [6:0] intl,
    input logic [15:0] programmable_function_terminal, input logic [7:0] trig, input logic star, input logic cmp);
    logic r;
    r = 1'b0;
    if (sel < SRC_PFI_BASE)
      r = intl[sel[2:0]];
    else if (sel < SRC_TRIG_BASE)
      r = programmable_function_terminal[4'(sel - SRC_PFI_BASE)];
    else if (sel < SRC_STAR)
      r = trig[3'(sel - SRC_TRIG_BASE)];
    else if (sel == SRC_STAR)
      r = star;
    else if (sel == SRC_CMP)
      r = cmp;
    return r;
  endfunction : pick_source

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [32:0] sync_a;
  logic [32:0] sync_b;
  wire [7:0] prim_sync = sync_b[7:0];
  wire [15:0] pfi_sync = sync_b[23:8];
  wire [7:0] trig_sync = sync_b[31:24];
  wire star_sync = sync_b[32];

  // two flops per pin; core clock stands in for the fast internal timebase
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      sync_a <= '0;
      sync_b <= '0;
    end
    else
    begin
      sync_a <= {star_trigger_in, intercard_trigger_bus_in, programmable_function_terminal_in, primary_port_in};
      sync_b <= sync_a;
    end
  end

  // ----------------------------------------
  // register file
  // ----------------------------------------
  ctrl_t ctrl;
  route_t route;
  logic [15:0] mode;
  logic [7:0] static_out;
  logic [15:0] cd_edge;
  logic [31:0] pwr_lo;
  logic [15:0] pwr_hi;
  logic [15:0] sec_dir;
  logic [15:0] sec_out;
  logic underflow;
  logic overrun;

  // apb decode; every access completes without wait states
  wire access = psel & penable;
  wire wr_en = access & pwrite;
  wire hit_ctrl = paddr == OFF_CTRL;
  wire hit_mode = paddr == OFF_MODE;
  wire hit_out = paddr == OFF_OUT;
  wire hit_in = paddr == OFF_IN;
  wire hit_status = paddr == OFF_STATUS;
  wire hit_cd = paddr == OFF_CD_EDGE;
  wire hit_route = paddr == OFF_ROUTE;
  wire hit_pwr_lo = paddr == OFF_PWR_LO;
  wire hit_pwr_hi = paddr == OFF_PWR_HI;
  wire hit_sec_dir = paddr == OFF_SEC_DIR;
  wire hit_sec_out = paddr == OFF_SEC_OUT;
  wire mapped = hit_ctrl | hit_mode | hit_out | hit_in | hit_status | hit_cd | hit_route
    | hit_pwr_lo | hit_pwr_hi | hit_sec_dir | hit_sec_out;
  wire fifo_clear = wr_en & hit_ctrl & pwdata[CTRL_CLEAR_BIT];
  wire apply_pwrup = wr_en & hit_ctrl & pwdata[CTRL_APPLY_BIT];
  wire clr_under = wr_en & hit_status & pwdata[ST_UNDER_BIT];
  wire clr_over = wr_en & hit_status & pwdata[ST_OVER_BIT];
  wire [31:0] pwr_all_lo = pwr_lo;
  wire [47:0] pwr_all = {pwr_hi, pwr_all_lo};
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;

  // plain configuration registers
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      ctrl <= ctrl_t'(REG_RST);
      route <= route_t'(REG_RST);
      cd_edge <= '0;
      pwr_lo <= REG_RST;
      pwr_hi <= '0;
    end
    else if (wr_en)
    begin
      if (hit_ctrl)
        ctrl <= ctrl_t'(pwdata & CTRL_MASK); // pulse bits are not stored
      if (hit_route)
        route <= route_t'(pwdata & ROUTE_MASK);
      if (hit_cd)
        cd_edge <= pwdata[15:0];
      if (hit_pwr_lo)
        pwr_lo <= pwdata;
      if (hit_pwr_hi)
        pwr_hi <= pwdata[15:0];
    end
  end

  // line configuration; apply copies the programmed power-up states
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      mode <= '0;
      static_out <= '0;
      sec_dir <= '0;
      sec_out <= '0;
    end
    else if (apply_pwrup)
    begin
      for (int i = 0; i < 8; i++)
      begin
        mode[2*i +: 2] <= pwr_drives(pwr_all[2*i +: 2]) ? MODE_STATIC : MODE_INPUT;
        static_out[i] <= pwr_all[2*i +: 2] == PWR_HIGH;
      end
      for (int i = 0; i < 16; i++)
      begin
        sec_dir[i] <= pwr_drives(pwr_all[16 + 2*i +: 2]);
        sec_out[i] <= pwr_all[16 + 2*i +: 2] == PWR_HIGH;
      end
    end
    else if (wr_en)
    begin
      if (hit_mode)
        mode <= pwdata[15:0];
      if (hit_out)
        static_out <= pwdata[7:0];
      if (hit_sec_dir)
        sec_dir <= pwdata[15:0];
      if (hit_sec_out)
        sec_out <= pwdata[15:0];
    end
  end

  // ----------------------------------------
  // strobe selection and edge
  // ----------------------------------------
  logic cd_event;
  logic strobe_prev;
  wire [6:0] internal_src = {cd_event, freq_gen_out, counter_internal_out, analog_out_sample_strobe,
    analog_in_convert_strobe, analog_in_sample_strobe};
  // no divider here: the strobe is always a routed signal
  wire strobe_raw = pick_source(ctrl.strobe_src, internal_src, pfi_sync, trig_sync, star_sync,
    analog_compare_event);
  wire strobe_edge = ctrl.falling_edge ? (strobe_prev & ~strobe_raw) : (~strobe_prev & strobe_raw);
  wire strobe_event = ctrl.gen_enable & strobe_edge;

  // ----------------------------------------
  // output fifo
  // ----------------------------------------
  logic [7:0] mem [FIFO_DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic [AW:0] base_ptr;
  logic [2:0] gap_cnt;
  logic [7:0] wave_level;
  wire [AW:0] level = wr_ptr - base_ptr;
  wire full = level == DEPTH_CNT;
  wire avail = ctrl.retransmit ? (wr_ptr != base_ptr) : (wr_ptr != rd_ptr);
  wire [AW:0] rd_inc = rd_ptr + 1'b1;
  wire [7:0] fifo_head = mem[rd_ptr[AW-1:0]];
  wire err_pending = underflow | overrun;
  wire take = strobe_event & ~err_pending;
  wire under_hit = take & ~avail;
  wire over_hit = take & avail & (gap_cnt != 3'h0);
  wire pop = take & avail & (gap_cnt == 3'h0);
  wire wrap = ctrl.retransmit & (rd_inc == wr_ptr);
  wire push = dma_valid & dma_ready;
  assign dma_ready = ~full & ~fifo_clear;

  // storage has no reset; the pointers decide what is valid
  always_ff @(posedge core_clk)
  begin
    if (push)
      mem[wr_ptr[AW-1:0]] <= dma_data;
  end

  // in retransmit the base stays put so the whole sequence replays
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || fifo_clear)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      base_ptr <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
      begin
        rd_ptr <= wrap ? base_ptr : rd_inc;
        if (!ctrl.retransmit)
          base_ptr <= rd_inc;
      end
    end
  end

  // sample register, fetch spacing and strobe history
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      wave_level <= '0;
      gap_cnt <= '0;
      strobe_prev <= 1'b0;
      pattern_out_strobe <= 1'b0;
    end
    else
    begin
      strobe_prev <= strobe_raw;
      pattern_out_strobe <= strobe_event;
      if (pop)
        wave_level <= fifo_head;
      if (pop)
        gap_cnt <= FETCH_GAP;
      else if (gap_cnt != 3'h0)
        gap_cnt <= gap_cnt - 3'h1;
    end
  end

  // sticky errors; a new error beats a clear in the same cycle
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      underflow <= 1'b0;
      overrun <= 1'b0;
    end
    else
    begin
      underflow <= under_hit | (underflow & ~clr_under);
      overrun <= over_hit | (overrun & ~clr_over);
    end
  end

  // ----------------------------------------
  // change detection
  // ----------------------------------------
  logic [7:0] cd_prev;
  logic [7:0] prim_level;
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      // driven lines are watched at the value we drive
      if (mode[2*i +: 2] == MODE_WAVE)
        prim_level[i] = wave_level[i];
      else if (mode[2*i +: 2] == MODE_STATIC)
        prim_level[i] = static_out[i];
      else
        prim_level[i] = prim_sync[i];
    end
  end
  wire [7:0] cd_hits = (~cd_prev & prim_level & cd_edge[7:0]) | (cd_prev & ~prim_level & cd_edge[15:8]);

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      cd_prev <= '0;
      cd_event <= 1'b0;
    end
    else
    begin
      cd_prev <= prim_level;
      cd_event <= |cd_hits;
    end
  end

  // ----------------------------------------
  // pin drivers and event outputs
  // ----------------------------------------
  // read data, captured in the setup cycle
  wire [31:0] status_word = (32'(level) << ST_LEVEL_POS) | 32'({~avail, full, overrun, underflow});
  wire [31:0] rd_mux = hit_ctrl ? 32'(ctrl) :
    hit_mode ? {16'h0000, mode} :
    hit_out ? {24'h000000, static_out} :
    hit_in ? {8'h00, pfi_sync, prim_sync} :
    hit_status ? status_word :
    hit_cd ? {16'h0000, cd_edge} :
    hit_route ? 32'(route) :
    hit_pwr_lo ? pwr_lo :
    hit_pwr_hi ? {16'h0000, pwr_hi} :
    hit_sec_dir ? {16'h0000, sec_dir} :
    hit_sec_out ? {16'h0000, sec_out} : 32'h00000000;
  wire [15:0] export_hit = {15'h0, ctrl.export_en} << ctrl.export_pfi;
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      primary_port_drive <= '{level: 8'h00, oe_n: 8'hff};
      programmable_function_terminal_drive <= '{level: 16'h0000, oe_n: 16'hffff};
      intercard_trigger_bus_drive <= '{level: 8'h00, oe_n: 8'hff};
      star_trigger_out <= 1'b0;
      star_trigger_oe_n <= 1'b1;
      change_event <= 1'b0;
      change_irq <= 1'b0;
      pattern_in_strobe <= 1'b0;
      prdata <= '0;
    end
    else
    begin
      for (int i = 0; i < 8; i++)
      begin
        primary_port_drive.level[i] <= (mode[2*i +: 2] == MODE_WAVE) ? wave_level[i] : static_out[i];
        primary_port_drive.oe_n[i] <= !(mode[2*i +: 2] == MODE_WAVE || mode[2*i +: 2] == MODE_STATIC);
      end
      for (int i = 0; i < 16; i++)
      begin
        // strobe export wins over the change event and the static value
        programmable_function_terminal_drive.level[i] <= export_hit[i] ? ~strobe_raw :
          (route.to_pfi[i] ? cd_event : sec_out[i]);
        programmable_function_terminal_drive.oe_n[i] <= ~(export_hit[i] | route.to_pfi[i] | sec_dir[i]);
      end
      intercard_trigger_bus_drive <= '{level: {8{cd_event}}, oe_n: ~route.to_trig};
      star_trigger_out <= cd_event;
      star_trigger_oe_n <= ~route.to_star;
      change_event <= cd_event;
      change_irq <= cd_event & route.irq_en;
      pattern_in_strobe <= cd_event & route.in_strobe;
      if (psel && !penable && !pwrite)
        prdata <= rd_mux;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_reset_hiz: assert property ($rose(rst_n) |-> primary_port_drive.oe_n == 8'hff
    && programmable_function_terminal_drive.oe_n == 16'hffff) else $error("lines driven after reset");
  a_under_flag: assert property (strobe_event && !err_pending && !avail |=> underflow)
    else $error("underflow not flagged");
  a_fetch_gap: assert property (pop |=> !pop [*3]) else $error("samples fetched too close");
  a_over_flag: assert property (over_hit |=> overrun && $stable(wave_level))
    else $error("overrun not flagged");
  a_err_hold: assert property (err_pending |=> $stable(wave_level))
    else $error("waveform moved while error pending");
  a_err_sticky: assert property (underflow && !clr_under |=> underflow)
    else $error("underflow dropped without clear");
  a_wave_load: assert property (pop |=> wave_level == $past(fifo_head))
    else $error("sample not moved on strobe");
  a_retx_wrap: assert property (pop && wrap |=> rd_ptr == $past(base_ptr))
    else $error("retransmit did not restart");
  a_cd_or: assert property (##1 cd_event == $past(|cd_hits))
    else $error("change event not the or of hits");
  a_pfi_invert: assert property (ctrl.export_en ##1 $stable(ctrl.export_pfi) |->
    programmable_function_terminal_drive.level[ctrl.export_pfi] == !$past(strobe_raw))
    else $error("exported strobe not inverted");
  c_retx_wrap: cover property (pop && wrap);
  c_underflow: cover property (under_hit);
  c_change: cover property (cd_event && route.irq_en);
endmodule : port_pattern_gen_change_detect

// *** logic/port_pattern_pkg.sv ***
// constants, register map and carrier types for the pattern port
package port_pattern_pkg;
  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_OUT = 8'h08;
  localparam logic [7:0] OFF_IN = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_CD_EDGE = 8'h14;
  localparam logic [7:0] OFF_ROUTE = 8'h18;
  localparam logic [7:0] OFF_PWR_LO = 8'h1c;
  localparam logic [7:0] OFF_PWR_HI = 8'h20;
  localparam logic [7:0] OFF_SEC_DIR = 8'h24;
  localparam logic [7:0] OFF_SEC_OUT = 8'h28;
  // ----------------------------------------
  // field layouts and reset values
  // ----------------------------------------
  localparam logic [31:0] CTRL_MASK = 32'h0003ff27;
  localparam logic [31:0] ROUTE_MASK = 32'hffff07ff;
  localparam logic [31:0] REG_RST = 32'h00000000;
  localparam int CTRL_CLEAR_BIT = 3;
  localparam int CTRL_APPLY_BIT = 4;
  localparam int ST_UNDER_BIT = 0;
  localparam int ST_OVER_BIT = 1;
  localparam int ST_LEVEL_POS = 8;
  localparam logic [1:0] MODE_INPUT = 2'h0;
  localparam logic [1:0] MODE_STATIC = 2'h1;
  localparam logic [1:0] MODE_WAVE = 2'h2;
  localparam logic [1:0] PWR_HIZ = 2'h0;
  localparam logic [1:0] PWR_LOW = 2'h1;
  localparam logic [1:0] PWR_HIGH = 2'h2;
  // strobe source codes: 0..6 internal, then terminals, trigger bus, star, comparator
  localparam logic [5:0] SRC_PFI_BASE = 6'h07;
  localparam logic [5:0] SRC_TRIG_BASE = 6'h17;
  localparam logic [5:0] SRC_STAR = 6'h1f;
  localparam logic [5:0] SRC_CMP = 6'h20;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int FETCH_CYCLES = 4;
  localparam logic [2:0] FETCH_GAP = 3'(FETCH_CYCLES - 1);
  // ----------------------------------------
  // carrier types
  // ----------------------------------------
  typedef struct packed {
    logic [13:0] unused_hi;
    logic [5:0] strobe_src;
    logic [3:0] export_pfi;
    logic [1:0] unused_lo;
    logic export_en;
    logic apply_pwrup;
    logic fifo_clear;
    logic falling_edge;
    logic retransmit;
    logic gen_enable;
  } ctrl_t;
  typedef struct packed {
    logic [15:0] to_pfi;
    logic [4:0] unused;
    logic in_strobe;
    logic irq_en;
    logic to_star;
    logic [7:0] to_trig;
  } route_t;
  typedef struct packed {
    logic [7:0] level;
    logic [7:0] oe_n;
  } drive8_t;
  typedef struct packed {
    logic [15:0] level;
    logic [15:0] oe_n;
  } drive16_t;
endpackage : port_pattern_pkg

// *** tb/pattern_far_side.sv ***
// far-side model: host dma source and primary port pins
`timescale 1ns/1ps
module pattern_far_side (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // dma stream
  output logic dma_valid = 1'b0,
  output logic [7:0] dma_data = 8'h00,
  input wire logic dma_ready,
  // primary port pins
  input wire port_pattern_pkg::drive8_t primary_port_drive,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] primary_port_in
);
  import port_pattern_pkg::*;
  logic [7:0] pend[$];

  // host memory bytes waiting for the dma engine
  task automatic push(input logic [7:0] b);
    pend.push_back(b);
  endtask : push

  // offer held until taken; idle data flips so a stale byte never looks valid
  always @(posedge core_clk)
  begin
    if (rst_n && dma_valid && dma_ready)
      void'(pend.pop_front());
    dma_valid <= rst_n && pend.size() > 0;
    dma_data <= (pend.size() > 0) ? pend[0] : ~dma_data;
  end

  // undriven lines sit on the weak pull-down
  assign primary_port_in = (~primary_port_drive.oe_n & primary_port_drive.level) |
    (primary_port_drive.oe_n & ext_en & ext_val);
endmodule : pattern_far_side

// *** tb/test_port_pattern_gen_change_detect.sv ***
// self-checking bench for the pattern port block
`timescale 1ns/1ps
module test_port_pattern_gen_change_detect;
  import port_pattern_pkg::*;
  // ----------------------------------------
  // stimulus, observation and bookkeeping
  // ----------------------------------------
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd_data, pw, pw2, rv;
  logic pready, pslverr, rd_err, dma_valid, dma_ready, star_out, star_oe_n, ev, irq, in_stb, out_stb;
  logic [7:0] dma_data, pin_in, rb;
  logic [7:0] ext_en = 8'h00;
  logic [7:0] ext_val = 8'h00;
  logic [32:0] src = '0;
  logic [7:0] samp [5];
  drive8_t pdrv, tdrv;
  drive16_t fdrv;
  int bad_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  int n_ev = 0;
  int n_irq = 0;
  int n_in = 0;
  int n_out = 0;
  int n_rt = 0;
  int unsigned seed;

  always #4 core_clk = ~core_clk;

  port_pattern_gen_change_detect #(.FIFO_DEPTH(16)) u_port_pattern_gen_change_detect (
    .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dma_valid(dma_valid), .dma_data(dma_data), .dma_ready(dma_ready),
    .analog_in_sample_strobe(src[0]), .analog_in_convert_strobe(src[1]),
    .analog_out_sample_strobe(src[2]), .counter_internal_out(src[4:3]), .freq_gen_out(src[5]),
    .analog_compare_event(src[32]), .primary_port_in(pin_in), .primary_port_drive(pdrv),
    .programmable_function_terminal_in(src[22:7]), .programmable_function_terminal_drive(fdrv),
    .intercard_trigger_bus_in(src[30:23]), .intercard_trigger_bus_drive(tdrv),
    .star_trigger_in(src[31]), .star_trigger_out(star_out), .star_trigger_oe_n(star_oe_n),
    .change_event(ev), .change_irq(irq), .pattern_in_strobe(in_stb), .pattern_out_strobe(out_stb));

  pattern_far_side u_pattern_far_side (
    .core_clk(core_clk), .rst_n(rst_n), .dma_valid(dma_valid), .dma_data(dma_data),
    .dma_ready(dma_ready), .primary_port_drive(pdrv), .ext_en(ext_en), .ext_val(ext_val),
    .primary_port_in(pin_in));

  // event pulse counters and the hang limit
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    n_ev <= n_ev + int'(ev === 1'b1);
    n_irq <= n_irq + int'(irq === 1'b1);
    n_in <= n_in + int'(in_stb === 1'b1);
    n_out <= n_out + int'(out_stb === 1'b1);
    // event seen on star, every trigger line and terminal 0 at once
    n_rt <= n_rt + int'(star_out === 1'b1 && star_oe_n === 1'b0 && tdrv === 16'hff00
      && fdrv.level[0] === 1'b1 && fdrv.oe_n[0] === 1'b0);
    if (cycles == 20000)
    begin
      bad_count++;
      report_and_stop;
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick

  // apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do
      @(posedge core_clk);
    while (pready !== 1'b1);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // one active edge on source c; idle level equals fe
  task automatic strobe(input int c, input logic fe);
    @(posedge core_clk);
    src[c] <= ~fe;
    @(posedge core_clk);
    src[c] <= fe;
    tick(8);
  endtask : strobe

  // power-up code per line to {level, oe_n}; codes 0 and 3 stay released
  function automatic logic [15:0] pwr_exp(input logic [15:0] p);
    logic [15:0] e;
    for (int i = 0; i < 8; i++)
    begin
      e[i] = !(p[2*i+:2] inside {2'h1, 2'h2});
      e[8+i] = p[2*i+:2] == 2'h2;
    end
    return e;
  endfunction : pwr_exp

  // source code table: internal, terminal, trigger bus, star, comparator
  function automatic int src_code(input int j);
    return j < 6 ? j : j == 6 ? 7 + $urandom_range(15) : j == 7 ? 23 + $urandom_range(7) : 23 + j;
  endfunction : src_code

  // retransmit run over every strobe source kind
  task automatic wave_run(input logic fe);
    int c;
    int b;
    src <= {33{fe}};
    apb(1, OFF_CTRL, 32'h8);
    for (int i = 0; i < 5; i++)
    begin
      samp[i] = 8'($urandom);
      u_pattern_far_side.push(samp[i]);
    end
    tick(20);
    b = n_out;
    for (int k = 0; k < 12; k++)
    begin
      c = src_code(k % 10);
      apb(1, OFF_CTRL, (32'(c) << 12) | (32'(fe) << 2) | 32'h3);
      strobe(c, fe);
      chk("wave level", pdrv.level, samp[k % 5]);
    end
    chk("out strobes", n_out - b, 12);
  endtask : wave_run

  task automatic report_and_stop;
    if (bad_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    seed = $urandom(31256);
    tick(6);
    rst_n <= 1'b1;
    tick(2);
    chk("released pins", {pdrv.oe_n, fdrv.oe_n, tdrv.oe_n, star_oe_n}, 33'h1ffffffff);
    apb(0, OFF_STATUS, 0);
    chk("status reset", rd_data, 32'h8);
    apb(0, 8'h40, 0);
    chk("unmapped", {rd_err, rd_data}, 33'h100000000);
    // static and input lines, mode readback
    rb = 8'($urandom);
    rv = $urandom;
    for (int i = 0; i < 8; i++)
      pw[2*i+:2] = {1'b0, rb[i]};
    apb(1, OFF_MODE, {16'h0, pw[15:0]});
    apb(1, OFF_OUT, rv);
    apb(0, OFF_MODE, 0);
    chk("mode readback", rd_data, {16'h0, pw[15:0]});
    tick(3);
    chk("static drive", {pdrv.oe_n, pdrv.level & rb}, {~rb, rv[7:0] & rb});
    // waveform generation on both polarities
    apb(1, OFF_MODE, 32'haaaa);
    wave_run(1'b0);
    wave_run(1'b1);
    // underflow, frozen output, overrun, clear
    src <= '0;
    apb(1, OFF_CTRL, 32'h8);
    samp[0] = 8'($urandom);
    samp[1] = ~samp[0];
    samp[2] = 8'($urandom);
    u_pattern_far_side.push(samp[0]);
    u_pattern_far_side.push(samp[1]);
    tick(10);
    apb(1, OFF_CTRL, 32'h1);
    strobe(0, 1'b0);
    strobe(0, 1'b0);
    chk("second sample", pdrv.level, samp[1]);
    strobe(0, 1'b0);
    apb(0, OFF_STATUS, 0);
    chk("underflow flag", rd_data[1:0], 2'b01);
    u_pattern_far_side.push(samp[2]);
    tick(10);
    strobe(0, 1'b0);
    chk("held output", pdrv.level, samp[1]);
    apb(1, OFF_STATUS, 32'h1);
    strobe(0, 1'b0);
    chk("after clear", pdrv.level, samp[2]);
    u_pattern_far_side.push(samp[0]);
    u_pattern_far_side.push(samp[1]);
    tick(10);
    repeat (2)
    begin
      @(posedge core_clk);
      src[0] <= 1'b1;
      @(posedge core_clk);
      src[0] <= 1'b0;
    end
    tick(8);
    apb(0, OFF_STATUS, 0);
    chk("overrun flag", rd_data[1:0], 2'b10);
    chk("overrun level", pdrv.level, samp[0]);
    apb(1, OFF_STATUS, 32'h2);
    // exported strobe is inverted on terminal 5
    apb(1, OFF_CTRL, 32'h520);
    src[0] <= 1'b1;
    tick(4);
    chk("export high", {fdrv.oe_n[5], fdrv.level[5]}, 2'b00);
    src[0] <= 1'b0;
    tick(4);
    chk("export low", {fdrv.oe_n[5], fdrv.level[5]}, 2'b01);
    // power-up states, chassis lines 0 1 2 4 left released
    pw = $urandom & 32'hfffffcc0;
    pw2 = $urandom;
    apb(1, OFF_PWR_LO, pw);
    apb(1, OFF_PWR_HI, pw2);
    apb(1, OFF_CTRL, 32'h10);
    tick(4);
    chk("powerup primary", pdrv, pwr_exp(pw[15:0]));
    rv = {pwr_exp(pw2[15:0]), pwr_exp(pw[31:16])};
    chk("powerup terminals", fdrv, {rv[31:24], rv[15:8], rv[23:16], rv[7:0]});
    // per-line direction on the shared ports
    pw = $urandom;
    apb(1, OFF_SEC_DIR, pw);
    apb(1, OFF_SEC_OUT, pw2);
    tick(4);
    chk("second ports", {fdrv.oe_n, fdrv.level & pw[15:0]}, {~pw[15:0], pw2[15:0] & pw[15:0]});
    // change detection: rise, fall, both, then a driven output line
    apb(1, OFF_MODE, 0);
    apb(1, OFF_ROUTE, 32'h107ff);
    // change event also serves as the output sample strobe (source code 6)
    apb(1, OFF_CTRL, 32'h6001);
    ext_en <= 8'hff;
    for (int e = 0; e < 4; e++)
    begin
      int r;
      int b;
      int o;
      int q;
      r = $urandom_range(7);
      apb(1, OFF_CD_EDGE, (e != 1 ? 32'h1 << r : 0) | (e == 1 || e == 2 ? 32'h100 << r : 0));
      if (e == 3)
      begin
        // low static value first, so the mode switch itself makes no edge
        apb(1, OFF_OUT, 0);
        apb(1, OFF_MODE, 32'h1 << (2 * r));
      end
      tick(4);
      b = n_ev;
      o = n_out;
      q = n_rt;
      pw = n_irq;
      pw2 = n_in;
      if (e == 3)
        apb(1, OFF_OUT, 32'h1 << r);
      else
        ext_val[r] <= 1'b1;
      tick(8);
      ext_val[r] <= 1'b0;
      if (e == 3)
        apb(1, OFF_OUT, 0);
      tick(8);
      chk("change events", n_ev - b, e == 2 ? 2 : 1);
      chk("irq and in strobe", {n_irq - pw, n_in - pw2}, {32'(n_ev - b), 32'(n_ev - b)});
      chk("routed pins", n_rt - q, e == 2 ? 2 : 1);
      chk("event as strobe", n_out - o, e == 2 ? 2 : 1);
    end
    report_and_stop;
  end
endmodule : test_port_pattern_gen_change_detect
